// ==== timer16_consts.vh ====
// constants for the 16-bit timer with two capture/compare registers
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
//
// Summary of operation
// - overflow flag at FFFFH to 0000H roll
// - clear before 0001H is overridden, flag stays
// - capture beats coincident write, read data undefined
// - capture coinciding with stop is undefined
// - first input as count clock: no capture
// - both edges on first input: no capture
// - source select set: no load, irq still
// - capture latched, irq at next count clock; with first input as count clock, irq at next ref_clk
// - compare-mode registers ignore capture triggers
// - input high at enable gives rising edge
// - high at stop, low at enable: falling
// - first input filtered, valid level sampled twice
// - ppg period first+1, active second+1
// - first input edge restarts soft one-shot too
// - unsafe second rewrite may toggle output
// - shared pin is input or output, never both
// - one-shot soft trigger self-clears, reads zero
// - counter runs whenever run mode is nonzero
`ifndef TIMER16_CONSTS_VH
`define TIMER16_CONSTS_VH
// register byte offsets
`define OFS_CTRL    5'h00
`define OFS_CAPCFG  5'h04
`define OFS_OUTCTL  5'h08
`define OFS_CC1     5'h0C
`define OFS_CC2     5'h10
`define OFS_COUNT   5'h14
// run modes
`define MODE_STOP   2'h0
`define MODE_FREE   2'h1
`define MODE_EDGE   2'h2
`define MODE_MATCH  2'h3
// edge selections
`define ES_FALL     2'h0
`define ES_RISE     2'h1
`define ES_BOTH     2'h3
// count clock sources
`define SRC_EXT     2'h3
`define MASK_DIV1   4'h0
`define MASK_DIV4   4'h3
`define MASK_DIV16  4'hF
// field positions
`define CTL_OVF     2
`define CFG_CAP1    0
`define CFG_CAP2    1
`define CFG_CSS     2
`define OUT_INV1    0
`define OUT_INV2    1
`define OUT_ONESHOT 2
`define OUT_TRIG    3
`define OUT_PIN_OE  4
// values
`define CNT_MAX     16'hFFFF
`define CNT_ZERO    16'h0000
`define WORD_ZERO   32'h0000_0000
`endif

// ==== timer16_capture_compare.v ====
// 16-bit timer/event counter with two capture/compare registers
// assumes inputs synchronous to ref_clk and a waitrequest-aware master
//
// The Avalon-MM interface to the registers and the placing of the registers were left to the implementer.
`default_nettype none
`include "timer16_consts.vh"
module timer16_capture_compare #(
  parameter CNT_W = 16
) (
  // clock and reset
  input  wire             ref_clk,
  input  wire             reset,
  // register bus
  input  wire [4:0]       avs_address,
  input  wire             avs_read,
  input  wire             avs_write,
  input  wire [31:0]      avs_writedata,
  output reg  [31:0]      avs_readdata,
  output reg              avs_waitrequest,
  // pins
  input  wire             edge_input_first,
  input  wire             shared_pin_in,
  output reg              shared_pin_out,
  output reg              shared_pin_oe,
  // event pulses
  output reg              match_irq_first,
  output reg              match_irq_second
);

  // edge qualification against a two-bit edge selection
  function edge_ok;
    input [1:0] es;
    input       rise;
    input       fall;
    begin
      edge_ok = (rise && (es == `ES_RISE || es == `ES_BOTH)) ||
                (fall && (es == `ES_FALL || es == `ES_BOTH));
    end
  endfunction

  reg  [1:0]       run_mode_r;
  reg              overflow_flag_r;
  reg              ovf_hold_r;
  reg              cap_first_r;
  reg              cap_second_r;
  reg              capture_source_select_r;
  reg  [1:0]       es_first_r;
  reg  [1:0]       es_second_r;
  reg  [1:0]       prescaler_mode_reg;
  reg              invert_on_first_match_r;
  reg              invert_on_second_match_r;
  reg              oneshot_en_r;
  reg              oneshot_soft_trigger_r;
  reg  [CNT_W-1:0] capcomp_first_r;
  reg  [CNT_W-1:0] capcomp_second_r;
  reg  [CNT_W-1:0] main_counter_r;
  reg  [3:0]       div_r;
  reg  [1:0]       samp1_r;
  reg  [1:0]       samp2_r;
  reg              flt1_r;
  reg              flt2_r;
  reg              prev1_r;
  reg              prev2_r;
  reg              irq1_due_r;
  reg              irq2_due_r;
  reg              level_r;

  wire run     = (run_mode_r != `MODE_STOP);
  wire bus_wr  = avs_write && !avs_waitrequest;
  wire ext_src = (prescaler_mode_reg == `SRC_EXT);

  // prescaler tick
  reg  [3:0] div_mask;
  always @*
  begin
    case (prescaler_mode_reg)
      2'h1:    div_mask = `MASK_DIV4;
      2'h2:    div_mask = `MASK_DIV16;
      default: div_mask = `MASK_DIV1;
    endcase
  end
  wire pre_tick = run && ((div_r & div_mask) == div_mask);

  always @(posedge ref_clk)
  begin
    if (reset || !run)
      div_r <= 4'h0;
    else
      div_r <= div_r + 4'h1;
  end

  // the second input is ignored while the pin drives
  wire in2 = shared_pin_oe ? 1'b0 : shared_pin_in;

  // first input sampled at ref_clk as count clock, else at tick
  wire samp1_en = ext_src ? 1'b1 : pre_tick;

  // noise filter: level accepted after two equal samples
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      samp1_r <= 2'h0;
      samp2_r <= 2'h0;
      flt1_r  <= 1'b0;
      flt2_r  <= 1'b0;
    end
    else
    begin
      if (samp1_en)
      begin
        samp1_r <= {samp1_r[0], edge_input_first};
        if (samp1_r[1] == samp1_r[0])
          flt1_r <= samp1_r[0];
      end
      if (pre_tick)
      begin
        samp2_r <= {samp2_r[0], in2};
        if (samp2_r[1] == samp2_r[0])
          flt2_r <= samp2_r[0];
      end
    end
  end

  // reference levels freeze while stopped, so a level change
  // across a stop shows up as an edge once the filter accepts the new level after enable
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      prev1_r <= 1'b0;
      prev2_r <= 1'b0;
    end
    else if (run)
    begin
      prev1_r <= flt1_r;
      prev2_r <= flt2_r;
    end
  end

  wire rise1 = run && flt1_r && !prev1_r;
  wire fall1 = run && !flt1_r && prev1_r;
  wire rise2 = run && flt2_r && !prev2_r;
  wire fall2 = run && !flt2_r && prev2_r;
  wire edge1 = edge_ok(es_first_r, rise1, fall1);
  wire edge2 = edge_ok(es_second_r, rise2, fall2);

  // count enable: prescaled clock or first input edges
  wire cnt_tick = run && (ext_src ? edge1 : pre_tick);

  // first input may not capture in these settings
  wire cap1_src_ok = !ext_src && (es_first_r != `ES_BOTH);

  // capture only for registers set to capture
  wire cap_into_first  = cap_first_r && (capture_source_select_r ? 1'b0 : edge2);
  wire cap_into_second = cap_second_r && edge1 && cap1_src_ok;

  // restart sources
  wire soft_trig  = bus_wr && avs_address == `OFS_OUTCTL &&
                    avs_writedata[`OUT_TRIG] && oneshot_en_r;
  // external edge restarts even in soft one-shot use
  wire clr_start  = run && (soft_trig || (edge1 && !ext_src &&
                    (run_mode_r == `MODE_EDGE || oneshot_en_r)));

  wire match1     = cnt_tick && main_counter_r == capcomp_first_r && !cap_first_r;
  wire match2     = cnt_tick && main_counter_r == capcomp_second_r && !cap_second_r;
  wire roll       = cnt_tick && (main_counter_r == `CNT_MAX ||
                    (run_mode_r == `MODE_MATCH && match1));

  // counter runs for any nonzero mode, held at zero when stopped
  always @(posedge ref_clk)
  begin
    if (reset || !run)
      main_counter_r <= `CNT_ZERO;
    else if (clr_start)
      main_counter_r <= `CNT_ZERO;
    else if (cnt_tick)
    begin
      if (run_mode_r == `MODE_MATCH && match1)
        main_counter_r <= `CNT_ZERO;
      else
        main_counter_r <= main_counter_r + 16'h0001;
    end
  end

  // overflow flag, the set beats any clear
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      overflow_flag_r <= 1'b0;
      ovf_hold_r      <= 1'b0;
    end
    else
    begin
      if (roll && main_counter_r == `CNT_MAX)
      begin
        overflow_flag_r <= 1'b1;
        ovf_hold_r      <= 1'b1;
      end
      else
      begin
        if (cnt_tick || !run)
          ovf_hold_r <= 1'b0;
        // clear ignored until the count leaves zero
        if (bus_wr && avs_address == `OFS_CTRL &&
            !avs_writedata[`CTL_OVF] && !ovf_hold_r)
          overflow_flag_r <= 1'b0;
      end
    end
  end

  // capture registers double as compare values
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      capcomp_first_r  <= `CNT_ZERO;
      capcomp_second_r <= `CNT_ZERO;
    end
    else
    begin
      // capture takes the bus write slot when both land
      if (cap_into_first)
        capcomp_first_r <= main_counter_r;
      else if (bus_wr && avs_address == `OFS_CC1)
        capcomp_first_r <= avs_writedata[CNT_W-1:0];
      if (cap_into_second)
        capcomp_second_r <= main_counter_r;
      else if (bus_wr && avs_address == `OFS_CC2)
        capcomp_second_r <= avs_writedata[CNT_W-1:0];
    end
  end

  // capture interrupts wait for the next prescaler tick, the next ref_clk when the first input is the count clock
  always @(posedge ref_clk)
  begin
    if (reset || !run)
    begin
      irq1_due_r <= 1'b0;
      irq2_due_r <= 1'b0;
    end
    else
    begin
      // latch now, interrupt at the following tick
      // first irq still raised when the source select suppresses the load
      if (cap_first_r && edge2)
        irq1_due_r <= 1'b1;
      else if (pre_tick)
        irq1_due_r <= 1'b0;
      if (cap_into_second)
        irq2_due_r <= 1'b1;
      else if (pre_tick)
        irq2_due_r <= 1'b0;
    end
  end

  // interrupt pulses, one cycle each
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      match_irq_first  <= 1'b0;
      match_irq_second <= 1'b0;
    end
    else
    begin
      // capture irq on the tick after the latch
      match_irq_first  <= match1 || (irq1_due_r && pre_tick);
      match_irq_second <= match2 || (irq2_due_r && pre_tick);
    end
  end

  // output level; a late compare rewrite can land on a match and
  // toggle once more, software must use the safe rewrite order
  always @(posedge ref_clk)
  begin
    if (reset || !run)
      level_r <= 1'b0;
    else if (clr_start && oneshot_en_r)
      level_r <= 1'b0;
    else if (oneshot_en_r)
    begin
      if (match2)
        level_r <= 1'b1;
      else if (match1)
        level_r <= 1'b0;
    end
    else
      // ppg: toggle at second, restart low after first
      level_r <= level_r ^ ((match1 && invert_on_first_match_r) ^
                            (match2 && invert_on_second_match_r));
  end

  // shared pin drive
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      shared_pin_out <= 1'b0;
      shared_pin_oe  <= 1'b0;
    end
    else
    begin
      // pin owned by output only when enabled
      shared_pin_oe  <= oneshot_soft_trigger_r;
      shared_pin_out <= oneshot_soft_trigger_r && level_r;
    end
  end

  // control registers
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      run_mode_r               <= `MODE_STOP;
      cap_first_r              <= 1'b0;
      cap_second_r             <= 1'b0;
      capture_source_select_r  <= 1'b0;
      es_first_r               <= `ES_FALL;
      es_second_r              <= `ES_FALL;
      prescaler_mode_reg       <= 2'h0;
      invert_on_first_match_r  <= 1'b0;
      invert_on_second_match_r <= 1'b0;
      oneshot_en_r             <= 1'b0;
      oneshot_soft_trigger_r   <= 1'b0;
    end
    else if (bus_wr)
    begin
      case (avs_address)
        `OFS_CTRL:
          run_mode_r <= avs_writedata[1:0];
        `OFS_CAPCFG:
        begin
          cap_first_r             <= avs_writedata[`CFG_CAP1];
          cap_second_r            <= avs_writedata[`CFG_CAP2];
          capture_source_select_r <= avs_writedata[`CFG_CSS];
          es_first_r              <= avs_writedata[5:4];
          es_second_r             <= avs_writedata[7:6];
          prescaler_mode_reg      <= avs_writedata[9:8];
        end
        `OFS_OUTCTL:
        begin
          invert_on_first_match_r  <= avs_writedata[`OUT_INV1];
          invert_on_second_match_r <= avs_writedata[`OUT_INV2];
          oneshot_en_r             <= avs_writedata[`OUT_ONESHOT];
          // pin ownership bit; trigger bit itself is never stored
          oneshot_soft_trigger_r   <= avs_writedata[`OUT_PIN_OE];
        end
        default:
          run_mode_r <= run_mode_r;
      endcase
    end
  end

  // read mux
  reg [31:0] rd_mux;
  always @*
  begin
    case (avs_address)
      `OFS_CTRL:
        rd_mux = {29'h0, overflow_flag_r, run_mode_r};
      `OFS_CAPCFG:
        rd_mux = {22'h0, prescaler_mode_reg, es_second_r, es_first_r,
                  1'b0, capture_source_select_r, cap_second_r, cap_first_r};
      `OFS_OUTCTL:
        rd_mux = {27'h0, oneshot_soft_trigger_r, 1'b0, oneshot_en_r,
                  invert_on_second_match_r, invert_on_first_match_r};
      `OFS_CC1:
        rd_mux = {16'h0, capcomp_first_r};
      `OFS_CC2:
        rd_mux = {16'h0, capcomp_second_r};
      `OFS_COUNT:
        rd_mux = {16'h0, main_counter_r};
      default:
        rd_mux = `WORD_ZERO;
    endcase
  end

  // bus handshake: one wait cycle, then the answer
  always @(posedge ref_clk)
  begin
    if (reset)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= `WORD_ZERO;
    end
    else if (!avs_waitrequest)
      avs_waitrequest <= 1'b1;
    else if (avs_read || avs_write)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= avs_read ? rd_mux : `WORD_ZERO;
    end
  end

endmodule // timer16_capture_compare
`default_nettype wire

// ==== timer16_capture_compare_props.sv ====
// checker for the timer register bus, event pulses and shared pin
// bound to the timer top module; sees its ports only
`default_nettype none
`include "timer16_consts.vh"
module timer16_checker #(
  parameter CNT_W = 16
) (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset,
  // register bus
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins and events
  input wire logic        edge_input_first,
  input wire logic        shared_pin_in,
  input wire logic        shared_pin_out,
  input wire logic        shared_pin_oe,
  input wire logic        match_irq_first,
  input wire logic        match_irq_second
);
  // one clock domain with synchronous reset
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // answered read, readdata stands in this cycle
  wire logic rd_ok;
  wire logic req;
  assign rd_ok = avs_read && !avs_waitrequest;
  assign req = avs_read || avs_write;
  // bus answers exactly one cycle after the request is taken
  a_answer_next_cycle: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer not one cycle after request");
  a_wait_low_once: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_idle_no_answer: assert property (!req |=> avs_waitrequest)
    else $error("answer without a request");
  a_pin_released_low: assert property (!shared_pin_oe |-> !shared_pin_out)
    else $error("pin output driven while released");
  a_first_irq_pulse: assert property (match_irq_first |=> !match_irq_first)
    else $error("first event pulse too long");
  a_second_irq_pulse: assert property (match_irq_second |=> !match_irq_second)
    else $error("second event pulse too long");
  a_trigger_reads_zero: assert property (rd_ok && avs_address == `OFS_OUTCTL |-> !avs_readdata[`OUT_TRIG])
    else $error("soft trigger bit read back as one");
  a_unmapped_zero: assert property (rd_ok && avs_address > `OFS_COUNT |-> avs_readdata == `WORD_ZERO)
    else $error("unmapped read not zero");
  a_upper_bits_zero: assert property (rd_ok |-> avs_readdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
endmodule // timer16_checker
`default_nettype wire

// ==== timer16_far_side.sv ====
// model of the edge sources and the load on the shared pin
// assumes the bench calls its tasks one at a time
`default_nettype none
module timer16_far_side (
  // clock
  input wire logic  ref_clk,
  // shared pin from the timer
  input wire logic  shared_pin_out,
  input wire logic  shared_pin_oe,
  // edge sources
  output logic      edge_input_first,
  output logic      shared_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic drive_second;
  assign shared_pin_in = shared_pin_oe ? shared_pin_out : drive_second;
  // quiet sources at start
  initial
  begin
    edge_input_first = 1'b0;
    drive_second = 1'b0;
  end
  task automatic pulse(input bit second, input int w);
    @(posedge ref_clk);
    if (second) drive_second <= 1'b1;
    else edge_input_first <= 1'b1;
    repeat ((w < 3) ? 3 : w) @(posedge ref_clk);
    if (second) drive_second <= 1'b0;
    else edge_input_first <= 1'b0;
  endtask
  // static level on the first input
  task automatic level(input logic v);
    @(posedge ref_clk);
    edge_input_first <= v;
  endtask
endmodule // timer16_far_side
`default_nettype wire

// ==== timer16_tb.sv ====
// self-checking bench for the 16-bit capture/compare timer
// assumes the far side model and the checker are compiled first
`default_nettype none
`include "timer16_consts.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        ref_clk, reset, avs_read, avs_write;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, rd, v;
  wire logic [31:0] avs_readdata;
  wire logic   avs_waitrequest, pin_out, pin_oe, irq1, irq2, first_in, second_in;
  int          errors = 0, checks = 0, n1 = 0, n2 = 0, h, l;
  logic [31:0] cfg [4] = '{32'h0000_0012, 32'h0000_0032, 32'h0000_0312, 32'h0000_0010};
  timer16_capture_compare #(.CNT_W(16)) u_dut (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .edge_input_first(first_in), .shared_pin_in(second_in),
    .shared_pin_out(pin_out), .shared_pin_oe(pin_oe), .match_irq_first(irq1), .match_irq_second(irq2));
  timer16_far_side u_far (.ref_clk(ref_clk), .shared_pin_out(pin_out), .shared_pin_oe(pin_oe),
    .edge_input_first(first_in), .shared_pin_in(second_in));
  // free-running clock, 20 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // count event pulses
  always @(posedge ref_clk)
  begin
    if (irq1 === 1'b1) n1 <= n1 + 1;
    if (irq2 === 1'b1) n2 <= n2 + 1;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus transfer; holds until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) chk("bus answer", 0, 1);
  endtask
  task automatic t_regs;
    for (int a = 0; a <= 24; a += 4)
    begin
      xfer(1'b0, a[4:0], 0);
      chk("reset value", `WORD_ZERO, rd);
    end
    xfer(1'b1, `OFS_COUNT, 32'h0000_1234);
    xfer(1'b1, 5'h18, 32'h0000_5678);
    xfer(1'b0, `OFS_COUNT, 0);
    chk("count read-only", 0, rd);
    xfer(1'b1, `OFS_OUTCTL, 32'h0000_000C);
    xfer(1'b0, `OFS_OUTCTL, 0);
    chk("outctl", 32'h0000_0004, rd);
    xfer(1'b1, `OFS_OUTCTL, 0);
  endtask
  task automatic t_run;
    xfer(1'b1, `OFS_CTRL, 32'h0000_0001);
    xfer(1'b0, `OFS_COUNT, 0);
    v = rd;
    xfer(1'b0, `OFS_COUNT, 0);
    chk("count runs", 1, {31'h0, rd != v});
    xfer(1'b1, `OFS_CTRL, 0);
    xfer(1'b0, `OFS_COUNT, 0);
    v = rd;
    xfer(1'b0, `OFS_COUNT, 0);
    chk("count held", v, rd);
  endtask
  // edges seen at enable, then capture on and off
  task automatic t_capture;
    u_far.level(1'b1);
    xfer(1'b1, `OFS_CAPCFG, 32'h0000_0012);
    v = n2;
    xfer(1'b1, `OFS_CTRL, 1);
    repeat (20) @(posedge ref_clk);
    chk("rise at enable", v + 1, n2);
    xfer(1'b1, `OFS_CTRL, 0);
    u_far.level(1'b0);
    xfer(1'b1, `OFS_CAPCFG, 32'h0000_0002);
    v = n2;
    xfer(1'b1, `OFS_CTRL, 1);
    repeat (20) @(posedge ref_clk);
    chk("fall at enable", v + 1, n2);
    xfer(1'b1, `OFS_CTRL, 0);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b1, `OFS_CAPCFG, 0);
      xfer(1'b1, `OFS_CC2, 32'h0000_FFF0);
      xfer(1'b1, `OFS_CAPCFG, cfg[i]);
      v = n2;
      xfer(1'b1, `OFS_CTRL, 1);
      u_far.pulse(1'b0, 4);
      repeat (10) @(posedge ref_clk);
      xfer(1'b0, `OFS_CC2, 0);
      chk("capture kept", {31'h0, i != 0}, {31'h0, rd == 32'h0000_FFF0});
      chk("capture event", v + (i == 0), n2);
      xfer(1'b1, `OFS_CTRL, 0);
    end
  endtask
  task automatic t_select;
    xfer(1'b1, `OFS_CAPCFG, 0);
    xfer(1'b1, `OFS_CC1, 32'h0000_1234);
    xfer(1'b1, `OFS_CAPCFG, 32'h0000_0045);
    v = n1;
    xfer(1'b1, `OFS_CTRL, 1);
    u_far.pulse(1'b1, 4);
    repeat (10) @(posedge ref_clk);
    chk("select event", v + 1, n1);
    xfer(1'b0, `OFS_CC1, 0);
    chk("select no load", 32'h0000_1234, rd);
    xfer(1'b1, `OFS_CTRL, 0);
  endtask
  task automatic t_ppg;
    xfer(1'b1, `OFS_CAPCFG, 0);
    // 0 < second < first, written while stopped
    // compare values only rewritten with the counter stopped
    xfer(1'b1, `OFS_CC1, 32'h0000_0009);
    xfer(1'b1, `OFS_CC2, 32'h0000_0003);
    xfer(1'b1, `OFS_OUTCTL, 32'h0000_0013);
    xfer(1'b1, `OFS_CTRL, 3);
    h = 0;
    l = 0;
    while (pin_out !== 1'b1 && h < 100) @(posedge ref_clk) h++;
    h = 0;
    while (pin_out === 1'b1 && h < 100) @(posedge ref_clk) h++;
    while (pin_out === 1'b0 && l < 100) @(posedge ref_clk) l++;
    chk("ppg active", 4, l);
    chk("ppg period", 10, h + l);
    chk("pin enable", 1, pin_oe);
    // counter stopped before anything else changes
    xfer(1'b1, `OFS_CTRL, 0);
    xfer(1'b1, `OFS_OUTCTL, 0);
  endtask
  // software one-shot: pulse spans first minus second count ticks
  task automatic t_oneshot;
    xfer(1'b1, `OFS_CAPCFG, 0);
    // no zero compare values in one-shot use
    xfer(1'b1, `OFS_CC1, 32'h0000_0020);
    xfer(1'b1, `OFS_CC2, 32'h0000_0018);
    xfer(1'b1, `OFS_OUTCTL, 32'h0000_0014);
    xfer(1'b1, `OFS_CTRL, 1);
    // a single trigger, none again while the pulse runs
    xfer(1'b1, `OFS_OUTCTL, 32'h0000_001C);
    h = 0;
    while (pin_out !== 1'b1 && h < 100) @(posedge ref_clk) h++;
    h = 0;
    while (pin_out === 1'b1 && h < 100) @(posedge ref_clk) h++;
    chk("oneshot width", 8, h);
    xfer(1'b1, `OFS_CTRL, 0);
    xfer(1'b1, `OFS_OUTCTL, 0);
  endtask
  task automatic t_overflow;
    int n;
    n = 0;
    xfer(1'b1, `OFS_CC1, 32'h0000_FFFF);
    xfer(1'b1, `OFS_CTRL, 1);
    do
    begin
      xfer(1'b0, `OFS_CTRL, 0);
      n++;
    end
    while (rd[`CTL_OVF] !== 1'b1 && n < 30000);
    chk("overflow set", 32'h0000_0005, rd);
    xfer(1'b1, `OFS_CTRL, 1);
    xfer(1'b0, `OFS_CTRL, 0);
    chk("overflow cleared", 32'h0000_0001, rd);
    xfer(1'b1, `OFS_CTRL, 0);
  endtask
  task automatic results;
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // hang guard
  initial
  begin
    #2_500_000;
    errors++;
    results;
  end
  // reset, then each scenario in turn
  initial
  begin
    reset = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 5'h00;
    avs_writedata = 32'h0000_0000;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs;
    t_run;
    t_capture;
    t_select;
    t_ppg;
    t_oneshot;
    t_overflow;
    results;
  end
endmodule // testbench
// checker beside the timer top
bind timer16_capture_compare timer16_checker #(.CNT_W(CNT_W)) u_chk (.ref_clk(ref_clk), .reset(reset),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .edge_input_first(edge_input_first),
  .shared_pin_in(shared_pin_in), .shared_pin_out(shared_pin_out), .shared_pin_oe(shared_pin_oe),
  .match_irq_first(match_irq_first), .match_irq_second(match_irq_second));
`default_nettype wire
